// ==== rtl/alarm_regs.svh ====
`ifndef ALARM_REGS_SVH
`define ALARM_REGS_SVH

// byte offsets inside the slave's window
`define ALM_ADDR_CTRL      8'h00
`define ALM_ADDR_WINDOW    8'h04
`define ALM_ADDR_STATUS    8'h08

// control register fields
`define ALM_UNLOCK_BIT     0
`define ALM_ENABLE_BIT     1
`define ALM_SEL_LSB        4
`define ALM_SEL_MSB        7
`define ALM_PTR_LSB        8
`define ALM_PTR_MSB        9
`define ALM_CTRL_MASK      16'h03f3
`define ALM_CTRL_RESET     16'h0000

// compare select bit positions
`define ALM_SEL_SEC        0
`define ALM_SEL_MIN        1
`define ALM_SEL_HOUR       2
`define ALM_SEL_WKDAY      3

// pointer values that open a word in the window
`define ALM_PTR_MIN_SEC    2'b00
`define ALM_PTR_WKDAY_HR   2'b01

// weekday/hours word layout
`define ALM_WKDAY_MSB      10
`define ALM_WKDAY_LSB      8
`define ALM_HOUR_TENS_MSB  5
`define ALM_HOUR_TENS_LSB  4
`define ALM_HOUR_UNITS_MSB 3
`define ALM_HOUR_UNITS_LSB 0
`define ALM_WH_MASK        16'h073f

// minutes/seconds word layout
`define ALM_MIN_TENS_MSB   14
`define ALM_MIN_TENS_LSB   12
`define ALM_MIN_UNITS_MSB  11
`define ALM_MIN_UNITS_LSB  8
`define ALM_SEC_TENS_MSB   6
`define ALM_SEC_TENS_LSB   4
`define ALM_SEC_UNITS_MSB  3
`define ALM_SEC_UNITS_LSB  0
`define ALM_MS_MASK        16'h7f7f

`define ALM_WORD_RESET     16'h0000

// status register fields
`define ALM_ST_EVENT_BIT   0
`define ALM_ST_MATCH_BIT   1
`define ALM_ST_REFUSED_BIT 2
`define ALM_ST_COUNT_LSB   8
`define ALM_ST_COUNT_MSB   15

`endif

// ==== rtl/alarm_pkg.sv ====
package alarm_pkg;

    // one alarm value word
    typedef logic [15:0] word_t;

    // which register a bus access targets
    typedef enum logic [1:0] {
        SEL_CTRL,
        SEL_WINDOW,
        SEL_STATUS,
        SEL_NONE
    } reg_sel_t;

    // data phase of the bus slave
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ
    } bus_phase_t;

endpackage : alarm_pkg

// ==== rtl/alarm_match.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "alarm_regs.svh"

module alarm_match (
    // clock and reset
    input  wire logic           hclk,
    input  wire logic           hresetn,
    // stored alarm values
    input  wire alarm_pkg::word_t alarm_wh,
    input  wire alarm_pkg::word_t alarm_ms,
    // live timekeeping values
    input  wire alarm_pkg::word_t time_wh,
    input  wire alarm_pkg::word_t time_ms,
    input  wire logic           time_update,
    // compare control
    input  wire logic           enable,
    input  wire logic [3:0]     field_sel,
    // results
    output logic                match_now,
    output logic                alarm_event
);
    import alarm_pkg::*;

    logic [3:0] hit;
    logic       all_hit;
    logic       next_match;
    logic       next_event;

    // per-field equality, tens and units digits together
    always_comb begin
        hit[`ALM_SEL_SEC]  =
            alarm_ms[`ALM_SEC_TENS_MSB:`ALM_SEC_UNITS_LSB] ==
            time_ms[`ALM_SEC_TENS_MSB:`ALM_SEC_UNITS_LSB];
        hit[`ALM_SEL_MIN]  =
            alarm_ms[`ALM_MIN_TENS_MSB:`ALM_MIN_UNITS_LSB] ==
            time_ms[`ALM_MIN_TENS_MSB:`ALM_MIN_UNITS_LSB];
        hit[`ALM_SEL_HOUR] =
            alarm_wh[`ALM_HOUR_TENS_MSB:`ALM_HOUR_UNITS_LSB] ==
            time_wh[`ALM_HOUR_TENS_MSB:`ALM_HOUR_UNITS_LSB];
        hit[`ALM_SEL_WKDAY] =
            alarm_wh[`ALM_WKDAY_MSB:`ALM_WKDAY_LSB] ==
            time_wh[`ALM_WKDAY_MSB:`ALM_WKDAY_LSB];
        // unselected fields never block a match
        all_hit = &(hit | ~field_sel);
    end

    // compare only on a clock update; event needs the enable
    always_comb begin
        next_match = time_update ? all_hit : match_now; // R11
        next_event = time_update & enable & all_hit;     // R11
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_now   <= 1'b0;
            alarm_event <= 1'b0;
        end else begin
            match_now   <= next_match;
            alarm_event <= next_event;
        end
    end

endmodule : alarm_match
`default_nettype wire

// ==== rtl/alarm_value_regs.sv ====
// Operation
// R1 - pointer 01 opens the weekday/hours word, 00 the minutes/seconds word.
// R2 - weekday is a three-bit field in bits 10..8, values 0 to 6.
// R3 - hour tens is a two-bit BCD field in bits 5..4, values 0 to 2.
// R4 - hour units is a four-bit BCD field in bits 3..0, values 0 to 9.
// R5 - minute tens is a three-bit BCD field in bits 14..12, values 0 to 5.
// R6 - minute units is a four-bit BCD field in bits 11..8, values 0 to 9.
// R7 - second tens is a three-bit BCD field in bits 6..4, values 0 to 5.
// R8 - second units is a four-bit BCD field in bits 3..0, values 0 to 9.
// R9 - unimplemented bits of both words read as zero.
// R10 - the weekday/hours word takes a write only while unlock is 1.
// R11 - each clock update compares selected fields and flags a match.
// R12 - software keeps the alarm off while it writes the alarm words.
// R13 - the alarm words can be read at any time, whatever the enables.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_regs.svh"

module alarm_value_regs #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // timekeeping compare path, same clock domain
    input  wire alarm_pkg::word_t  time_weekday_hours,
    input  wire alarm_pkg::word_t  time_minutes_seconds,
    input  wire logic              time_update,
    // alarm side
    output logic                   alarm_event,
    output logic                   alarm_enable_bit,
    output logic                   clock_write_unlock,
    output logic [1:0]             alarm_word_pointer
);
    import alarm_pkg::*;

    // address phase capture
    bus_phase_t  phase;
    bus_phase_t  next_phase;
    reg_sel_t    sel_q;
    reg_sel_t    next_sel;
    logic [3:0]  lanes_q;
    logic [3:0]  next_lanes;
    logic        addr_valid;
    reg_sel_t    addr_sel;

    // control fields
    logic        unlock;
    logic        next_unlock;
    logic        enable;
    logic        next_enable;
    logic [3:0]  cmp_sel;
    logic [3:0]  next_cmp_sel;
    logic [1:0]  ptr;
    logic [1:0]  next_ptr;
    word_t       ctrl_view;
    word_t       next_ctrl_view;
    word_t       ctrl_wr;

    // alarm value words
    word_t       word_wh;
    word_t       next_word_wh;
    word_t       word_ms;
    word_t       next_word_ms;

    // status
    logic        event_seen;
    logic        next_event_seen;
    logic        refused;
    logic        next_refused;
    logic [7:0]  event_count;
    logic [7:0]  next_event_count;
    logic        match_now;
    word_t       next_status_view;

    // read data
    logic [31:0] next_hrdata;

    // data phase strobes
    logic        wr_ctrl;
    logic        wr_window;
    logic        wr_status;

    // which register an address names; upper bits must be clear
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
        reg_sel_t s;
        s = SEL_NONE;
        if (a[ADDR_W-1:8] == '0) begin
            case (a[7:0])
                `ALM_ADDR_CTRL:   s = SEL_CTRL;
                `ALM_ADDR_WINDOW: s = SEL_WINDOW;
                `ALM_ADDR_STATUS: s = SEL_STATUS;
                default:          s = SEL_NONE;
            endcase
        end
        return s;
    endfunction : decode

    // byte lanes touched by an access of the given size
    function automatic logic [3:0] lane_mask(input logic [2:0] size,
                                             input logic [1:0] a);
        logic [3:0] m;
        case (size)
            3'h0:    m = 4'h1 << a;
            3'h1:    m = a[1] ? 4'hc : 4'h3;
            default: m = 4'hf;
        endcase
        return m;
    endfunction : lane_mask

    // merge written bytes into the low half-word
    function automatic word_t merge(input word_t old,
                                    input logic [15:0] wd,
                                    input logic [1:0] ln);
        word_t r;
        r[15:8] = ln[1] ? wd[15:8] : old[15:8];
        r[7:0]  = ln[0] ? wd[7:0]  : old[7:0];
        return r;
    endfunction : merge

    // zero wait states, always an okay response
    always_comb begin
        hreadyout = 1'b1;
        hresp     = 1'b0;
    end

    // address phase decode
    always_comb begin
        addr_valid = hsel & hready & htrans[1];
        addr_sel   = decode(haddr[ADDR_W-1:0]);
        next_phase = BUS_IDLE;
        next_sel   = sel_q;
        next_lanes = lanes_q;
        if (addr_valid) begin
            next_phase = hwrite ? BUS_WRITE : BUS_READ;
            next_sel   = addr_sel;
            next_lanes = lane_mask(hsize, haddr[1:0]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase   <= BUS_IDLE;
            sel_q   <= SEL_NONE;
            lanes_q <= 4'h0;
        end else begin
            phase   <= next_phase;
            sel_q   <= next_sel;
            lanes_q <= next_lanes;
        end
    end

    // write strobes live in the data phase, when hwdata stands
    always_comb begin
        wr_ctrl   = (phase == BUS_WRITE) && (sel_q == SEL_CTRL);
        wr_window = (phase == BUS_WRITE) && (sel_q == SEL_WINDOW);
        wr_status = (phase == BUS_WRITE) && (sel_q == SEL_STATUS);
    end

    // control register, packed view and update
    always_comb begin
        ctrl_view = 16'h0000;
        ctrl_view[`ALM_UNLOCK_BIT] = unlock;
        ctrl_view[`ALM_ENABLE_BIT] = enable;
        ctrl_view[`ALM_SEL_MSB:`ALM_SEL_LSB] = cmp_sel;
        ctrl_view[`ALM_PTR_MSB:`ALM_PTR_LSB] = ptr;
        ctrl_wr = merge(ctrl_view, hwdata[15:0], lanes_q[1:0]);
        next_ctrl_view = wr_ctrl ? (ctrl_wr & `ALM_CTRL_MASK)
                                 : ctrl_view;
        next_unlock  = next_ctrl_view[`ALM_UNLOCK_BIT];
        next_enable  = next_ctrl_view[`ALM_ENABLE_BIT];
        next_cmp_sel = next_ctrl_view[`ALM_SEL_MSB:`ALM_SEL_LSB];
        next_ptr     = next_ctrl_view[`ALM_PTR_MSB:`ALM_PTR_LSB];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unlock  <= 1'b0;
            enable  <= 1'b0;
            cmp_sel <= 4'h0;
            ptr     <= `ALM_PTR_MIN_SEC;
        end else begin
            unlock  <= next_unlock;
            enable  <= next_enable;
            cmp_sel <= next_cmp_sel;
            ptr     <= next_ptr;
        end
    end

    // alarm words behind the shared window; only implemented bits
    // are stored so the unused ones can never read back as one
    always_comb begin
        next_word_wh = word_wh;
        next_word_ms = word_ms;
        next_refused = refused;
        if (wr_window) begin
            unique case (ptr)
                `ALM_PTR_WKDAY_HR: begin // R1
                    if (unlock) begin // R10
                        next_word_wh = merge(word_wh, hwdata[15:0],
                                             lanes_q[1:0])
                                       & `ALM_WH_MASK; // R2 R3 R4 R9
                    end else begin
                        next_refused = 1'b1; // R10
                    end
                end
                `ALM_PTR_MIN_SEC: begin // R1
                    next_word_ms = merge(word_ms, hwdata[15:0],
                                         lanes_q[1:0])
                                   & `ALM_MS_MASK; // R5 R6 R7 R8 R9
                end
                // month/day word lives outside this block
                default: begin
                    next_word_wh = word_wh;
                end
            endcase
        end
        // a refusal in the same cycle as its clear still shows
        if (wr_status && lanes_q[0] &&
            hwdata[`ALM_ST_REFUSED_BIT] &&
            !(wr_window && ptr == `ALM_PTR_WKDAY_HR && !unlock)) begin
            next_refused = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_wh <= `ALM_WORD_RESET;
            word_ms <= `ALM_WORD_RESET;
            refused <= 1'b0;
        end else begin
            word_wh <= next_word_wh;
            word_ms <= next_word_ms;
            refused <= next_refused;
        end
    end

    // comparator against the live clock
    alarm_match u_match (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .alarm_wh    (word_wh),
        .alarm_ms    (word_ms),
        .time_wh     (time_weekday_hours),
        .time_ms     (time_minutes_seconds),
        .time_update (time_update),
        .enable      (enable),
        .field_sel   (cmp_sel),
        .match_now   (match_now),
        .alarm_event (alarm_event) // R11
    );

    // event history; a new event beats a clear in the same cycle
    always_comb begin
        next_event_seen  = event_seen;
        next_event_count = event_count;
        if (wr_status && lanes_q[0] && hwdata[`ALM_ST_EVENT_BIT]) begin
            next_event_seen = 1'b0;
        end
        if (alarm_event) begin
            next_event_seen  = 1'b1; // R11
            next_event_count = event_count + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_seen  <= 1'b0;
            event_count <= 8'h00;
        end else begin
            event_seen  <= next_event_seen;
            event_count <= next_event_count;
        end
    end

    // status view from next values, match bit from current match_now, so no write or event is missed
    always_comb begin
        next_status_view = 16'h0000;
        next_status_view[`ALM_ST_EVENT_BIT]   = next_event_seen;
        next_status_view[`ALM_ST_MATCH_BIT]   = match_now;
        next_status_view[`ALM_ST_REFUSED_BIT] = next_refused;
        next_status_view[`ALM_ST_COUNT_MSB:`ALM_ST_COUNT_LSB] =
            next_event_count;
    end

    // read data formed from next values so a read right behind a
    // write returns the written value without a wait state
    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (addr_valid && !hwrite) begin
            unique case (addr_sel)
                SEL_CTRL: begin
                    next_hrdata[15:0] = next_ctrl_view;
                end
                SEL_WINDOW: begin
                    // readable whatever unlock and enable say
                    unique case (next_ptr)
                        `ALM_PTR_WKDAY_HR: begin
                            next_hrdata[15:0] = next_word_wh; // R1 R13
                        end
                        `ALM_PTR_MIN_SEC: begin
                            next_hrdata[15:0] = next_word_ms; // R1 R13
                        end
                        default: begin
                            next_hrdata[15:0] = 16'h0000;
                        end
                    endcase
                end
                SEL_STATUS: begin
                    next_hrdata[15:0] = next_status_view;
                end
                SEL_NONE: begin
                    next_hrdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= next_hrdata;
        end
    end

    // control bits out to the rest of the clock unit
    always_comb begin
        alarm_enable_bit   = enable;
        clock_write_unlock = unlock;
        alarm_word_pointer = ptr;
    end

endmodule : alarm_value_regs
`default_nettype wire

// ==== verif/alarm_value_regs_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "alarm_regs.svh"

module alarm_value_regs_checker (
    // clock and reset
    input wire logic             hclk,
    input wire logic             hresetn,
    // ahb-lite slave
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic [2:0]       hsize,
    input wire logic [31:0]      hwdata,
    input wire logic             hready,
    input wire logic             hreadyout,
    input wire logic             hresp,
    input wire logic [31:0]      hrdata,
    // compare path
    input wire alarm_pkg::word_t time_weekday_hours,
    input wire alarm_pkg::word_t time_minutes_seconds,
    input wire logic             time_update,
    // alarm side
    input wire logic             alarm_event,
    input wire logic             alarm_enable_bit,
    input wire logic             clock_write_unlock,
    input wire logic [1:0]       alarm_word_pointer
);
    import alarm_pkg::*;
    logic win;
    logic rd_ms;
    logic rd_wh;
    logic wr_ms;
    logic wr_wh;

    // window accesses as taken in the address phase
    assign win   = hsel && hready && htrans[1] && haddr[11:0] == 12'h004;
    assign rd_ms = win && !hwrite && alarm_word_pointer == `ALM_PTR_MIN_SEC;
    assign rd_wh = win && !hwrite && alarm_word_pointer == `ALM_PTR_WKDAY_HR;
    assign wr_ms = win && hwrite && hsize == 3'b010
                   && alarm_word_pointer == `ALM_PTR_MIN_SEC;
    assign wr_wh = win && hwrite && hsize == 3'b010 && clock_write_unlock
                   && alarm_word_pointer == `ALM_PTR_WKDAY_HR;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_OKAY: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered with an error");
    AST_UPPER: assert property (hrdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    AST_WH_ZERO: assert property (
        rd_wh |=> (hrdata[15:0] & ~`ALM_WH_MASK) == 16'h0)
        else $error("weekday/hours spare bits not zero");
    AST_MS_ZERO: assert property (
        rd_ms |=> (hrdata[15:0] & ~`ALM_MS_MASK) == 16'h0)
        else $error("minutes/seconds spare bits not zero");
    AST_PTR_HIGH: assert property (
        win && !hwrite && alarm_word_pointer[1] |=> hrdata == 32'h0)
        else $error("unused pointer value returned data");
    AST_MS_BACK: assert property (
        wr_ms ##2 rd_ms |=>
            hrdata == ($past(hwdata, 2) & {16'h0, `ALM_MS_MASK}))
        else $error("minutes/seconds word not read back");
    AST_WH_BACK: assert property (
        wr_wh ##2 rd_wh |=>
            hrdata == ($past(hwdata, 2) & {16'h0, `ALM_WH_MASK}))
        else $error("unlocked weekday/hours word not read back");
    AST_EV_CAUSE: assert property (
        alarm_event |-> $past(time_update) && $past(alarm_enable_bit))
        else $error("alarm event without an enabled update");
    AST_EV_OFF: assert property (
        time_update && !alarm_enable_bit |=> !alarm_event)
        else $error("alarm event while disabled");
endmodule : alarm_value_regs_checker

bind alarm_value_regs alarm_value_regs_checker chk_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .time_weekday_hours(time_weekday_hours),
    .time_minutes_seconds(time_minutes_seconds),
    .time_update(time_update), .alarm_event(alarm_event),
    .alarm_enable_bit(alarm_enable_bit),
    .clock_write_unlock(clock_write_unlock),
    .alarm_word_pointer(alarm_word_pointer)
);
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "alarm_regs.svh"

module tb;
    import alarm_pkg::*;
    localparam logic [31:0] A_CTRL = {24'h0, `ALM_ADDR_CTRL};
    localparam logic [31:0] A_WIN  = {24'h0, `ALM_ADDR_WINDOW};
    localparam logic [31:0] A_STAT = {24'h0, `ALM_ADDR_STATUS};
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic        time_update, alarm_event, alarm_enable_bit;
    logic        clock_write_unlock;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, alarm_word_pointer;
    logic [2:0]  hsize;
    word_t       time_wh, time_ms;
    int          error_cnt, check_count;

    assign hready = hreadyout; // only slave on the bus

    alarm_value_regs dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .time_weekday_hours(time_wh),
        .time_minutes_seconds(time_ms), .time_update(time_update),
        .alarm_event(alarm_event), .alarm_enable_bit(alarm_enable_bit),
        .clock_write_unlock(clock_write_unlock),
        .alarm_word_pointer(alarm_word_pointer)
    );

    // 40 mhz clock
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task stop_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // bounded wait so a stuck slave cannot hang the run
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            $display("bus wait ran out");
            stop_test();
        end
    endtask : wait_ready

    // one single word transfer, address phase then data phase
    task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        hsize  <= 3'b010;
        wait_ready();
        htrans <= 2'b00;
        if (wr)
            hwdata <= d;
        wait_ready();
        rd = hrdata; // value before this edge's updates land
    endtask : xfer

    task rd_chk(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rd_chk

    function automatic logic [31:0] ctrl(input logic [1:0] p,
        input logic [3:0] s, input logic en, input logic unl);
        return {22'h0, p, s, 2'b00, en, unl};
    endfunction : ctrl

    // one update pulse, event judged in the following cycle
    task pulse(input logic exp);
        time_update <= 1'b1;
        @(posedge hclk);
        time_update <= 1'b0;
        #1;
        chk({31'h0, alarm_event}, {31'h0, exp});
        @(posedge hclk);
    endtask : pulse

    task t_reset;
        chk({30'h0, alarm_word_pointer}, 32'h0);
        rd_chk(A_CTRL, 32'h0);
        rd_chk(A_STAT, 32'h0);
        rd_chk(A_WIN, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task t_min_sec;
        xfer(1'b1, A_CTRL, ctrl(`ALM_PTR_MIN_SEC, 4'h0, 1'b0, 1'b0));
        xfer(1'b1, A_WIN, 32'hffff_ffff);
        rd_chk(A_WIN, 32'h7f7f);
        xfer(1'b1, A_WIN, 32'h5959);
        rd_chk(A_WIN, 32'h5959);
        $display("test minutes seconds done");
    endtask : t_min_sec

    task t_alarm_weekday_field_hours;
        xfer(1'b1, A_CTRL, ctrl(`ALM_PTR_WKDAY_HR, 4'h0, 1'b0, 1'b0));
        xfer(1'b1, A_WIN, 32'h0623);
        // control write has landed by now, pins are settled
        chk({30'h0, alarm_word_pointer}, 32'h1);
        chk({31'h0, clock_write_unlock}, 32'h0);
        rd_chk(A_WIN, 32'h0);
        rd_chk(A_STAT, 32'h4);
        xfer(1'b1, A_STAT, 32'h4);
        xfer(1'b1, A_CTRL, ctrl(`ALM_PTR_WKDAY_HR, 4'h0, 1'b0, 1'b1));
        xfer(1'b1, A_WIN, 32'hffff_ffff);
        chk({31'h0, clock_write_unlock}, 32'h1);
        rd_chk(A_WIN, 32'h073f);
        xfer(1'b1, A_WIN, 32'h0623);
        rd_chk(A_WIN, 32'h0623);
        xfer(1'b1, A_CTRL, ctrl(2'b10, 4'h0, 1'b0, 1'b1));
        xfer(1'b1, A_WIN, 32'h1234);
        rd_chk(A_WIN, 32'h0);
        xfer(1'b1, A_CTRL, ctrl(`ALM_PTR_MIN_SEC, 4'h0, 1'b0, 1'b0));
        rd_chk(A_WIN, 32'h5959);
        $display("test weekday hours done");
    endtask : t_alarm_weekday_field_hours

    // words were written with the alarm off, enable only now
    task t_alarm;
        time_ms <= 16'h5959;
        time_wh <= 16'h0623;
        xfer(1'b1, A_CTRL, ctrl(`ALM_PTR_WKDAY_HR, 4'hf, 1'b1, 1'b0));
        pulse(1'b1);
        chk({31'h0, alarm_enable_bit}, 32'h1);
        rd_chk(A_WIN, 32'h0623);
        time_ms <= 16'h5958;
        pulse(1'b0);
        xfer(1'b1, A_CTRL, ctrl(`ALM_PTR_WKDAY_HR, 4'hc, 1'b1, 1'b0));
        pulse(1'b1);
        time_ms <= 16'h5959;
        xfer(1'b1, A_CTRL, ctrl(`ALM_PTR_WKDAY_HR, 4'hf, 1'b0, 1'b0));
        pulse(1'b0);
        chk({31'h0, alarm_enable_bit}, 32'h0);
        rd_chk(A_STAT, 32'h0203);
        rd_chk(A_WIN, 32'h0623);
        $display("test alarm compare done");
    endtask : t_alarm

    task t_unmapped;
        rd_chk(32'h0000_000c, 32'h0);
        xfer(1'b1, 32'h0000_0100, 32'hffff_ffff);
        rd_chk(32'h0000_0100, 32'h0);
        rd_chk(A_CTRL, ctrl(`ALM_PTR_WKDAY_HR, 4'hf, 1'b0, 1'b0));
        $display("test unmapped done");
    endtask : t_unmapped

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        time_update = 1'b0;
        time_wh = 16'h0;
        time_ms = 16'h0;
        error_cnt = 0;
        check_count = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_min_sec();
        t_alarm_weekday_field_hours();
        t_alarm();
        t_unmapped();
        stop_test();
    end
endmodule : tb
`default_nettype wire
